// ===== logic/ueri_pkg.sv
package ueri_pkg;
    // Register addresses on the three address lines
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IER  = 3'h1;
    localparam logic [2:0] ADR_ISR  = 3'h2;
    localparam logic [2:0] ADR_LCR  = 3'h3;
    localparam logic [2:0] ADR_LSR  = 3'h5;
    localparam logic [2:0] ADR_MSR  = 3'h6;
    localparam logic [2:0] ADR_SCR  = 3'h7;
    // Key value of line_control that opens the enhanced bank
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    // Field positions
    localparam int LCR_DLAB  = 7;
    localparam int EFR_ENH   = 4;
    localparam int ENHANCED_MODE_SELECT_IMM  = 6;
    localparam int FEATURE_CONTROL_SEL  = 6;
    localparam int FCR_EN    = 0;
    localparam int FCR_RXRST = 1;
    localparam int FCR_TXRST = 2;
    localparam int IER_RX    = 0;
    localparam int IER_TX    = 1;
    localparam int IER_LS    = 2;
    localparam int IER_MS    = 3;
    // Values after reset
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [3:0] DLD_RST  = 4'h0;
    // interrupt_status source codes, bits 5:0
    localparam logic [5:0] ISR_LSR  = 6'h06;
    localparam logic [5:0] ISR_RXD  = 6'h04;
    localparam logic [5:0] ISR_TXR  = 6'h02;
    localparam logic [5:0] ISR_MSR  = 6'h00;
    localparam logic [5:0] ISR_NONE = 6'h01;
endpackage

// ===== logic/ueri_regs.sv
`timescale 1ns/100ps
// Contract
// - Divisor bytes at 000/001 when divisor enable set
// - Interrupt mask gates four sources into status
// - FIFO mode: receive interrupt at trigger level
// - Status and interrupt drop below trigger together
// - Data ready set on load, clear empty
// - All masks clear with FIFOs gives polled mode
// - Line status bit 1 flags receive overrun
// - Bits 2-4 report head character errors
// - Bit 5 holding empty, bit 6 all empty
// - Bit 7 set while any FIFO error
// - Mask bit 0 enables receive ready interrupt
// - Mask bit 1 enables transmit ready interrupt
// - Enabling transmit while empty interrupts at once
// - Mask bit 2 enables line status interrupt
// - Overrun raises line status interrupt immediately
// - Other errors on readout unless immediate bit
// - Mask bit 3 enables modem status interrupt
// - Status read returns highest priority pending source
// - Line status read clears its interrupt
// - Status read reporting transmit or holding write clears transmit
// - Modem status read clears modem interrupt
module ueri_regs #(
    parameter logic [7:0] P_REV_ID = 8'h01,  // Arbitrary revision value
    parameter logic [7:0] P_DEV_ID = 8'h5c,  // Arbitrary identifier value
    parameter int         P_LVL_W  = 7       // FIFO level width
) (
    // Clock and reset
    input  wire logic               i_mclk,
    input  wire logic               i_rstn,
    // Host parallel bus
    input  wire logic               i_cs_n,
    input  wire logic               i_rd_n,
    input  wire logic               i_wr_n,
    input  wire logic [2:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    output logic      [7:0]         o_rdata,
    output logic                    o_rdata_oe_n,
    // Receive side status
    input  wire logic [P_LVL_W-1:0] i_rx_level,
    input  wire logic [P_LVL_W-1:0] i_rx_trig,
    input  wire logic [7:0]         i_rhr_data,
    input  wire logic               i_overrun,
    input  wire logic               i_err_recv,
    input  wire logic [2:0]         i_head_err,
    input  wire logic               i_fifo_err_any,
    // Transmit side status
    input  wire logic [P_LVL_W-1:0] i_tx_level,
    input  wire logic               i_tx_below_trig,
    input  wire logic               i_thr_empty,
    input  wire logic               i_tx_all_empty,
    // Modem status
    input  wire logic [7:0]         i_msr,
    // Strobes to the channel
    output logic                    o_rhr_rd,
    output logic                    o_msr_rd,
    output logic                    o_thr_wr,
    output logic      [7:0]         o_thr_data,
    output logic                    o_rx_fifo_rst,
    output logic                    o_tx_fifo_rst,
    // Configuration to the channel
    output logic      [7:0]         o_line_control,
    output logic      [7:0]         o_fifo_control,
    output logic      [15:0]        o_divisor,
    output logic      [3:0]         o_divisor_fraction,
    output logic      [7:0]         o_fifo_trigger_level,
    output logic      [7:0]         o_feature_control,
    output logic      [7:0]         o_enhanced_function,
    output logic      [7:0]         o_enhanced_mode_select,
    output logic      [31:0]        o_flow_chars,
    // Interrupt request, active high
    output logic                    o_int
);

    // Address match, shared by read and write decode
    function automatic logic is_adr(input logic [2:0] a, input logic [2:0] k);
        is_adr = (a == k);
    endfunction

    // Two-stage synchroniser on the strobes, {wr_n, rd_n, cs_n}
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic       rd_act_q;  // Previous read strobe level
    logic       wr_act_q;  // Previous write strobe level

    // Strobe levels and leading-edge events
    wire rd_act = ~pin_s2_q[0] & ~pin_s2_q[1];
    wire wr_act = ~pin_s2_q[0] & ~pin_s2_q[2];
    wire rd_ev  = rd_act & ~rd_act_q;
    wire wr_ev  = wr_act & ~wr_act_q;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else begin
            pin_s1_q <= {i_wr_n, i_rd_n, i_cs_n};
            pin_s2_q <= pin_s1_q;
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
        end
    end

    // Configuration registers
    logic [7:0] lcr_q;
    logic [7:0] ier_q;
    logic [7:0] fcr_q;
    logic [7:0] dll_q;
    logic [7:0] dlm_q;
    logic [3:0] dld_q;
    logic [7:0] trg_q;
    logic [7:0] feature_control_q;
    logic [7:0] efr_q;
    logic [7:0] enhanced_mode_select_q;
    logic [7:0] spr_q;
    logic [7:0] flow_q [4];  // Resume one/two, pause one/two

    // Bank selection from line_control
    wire enh_bank = (lcr_q == ueri_pkg::LCR_ENH_KEY);
    wire dlab     = lcr_q[ueri_pkg::LCR_DLAB] & ~enh_bank;
    wire std_bank = ~lcr_q[ueri_pkg::LCR_DLAB];
    wire enh_ena  = efr_q[ueri_pkg::EFR_ENH];
    wire id_sel   = (dll_q == 8'h00) & (dlm_q == 8'h00);
    wire isr_vis  = ~enh_bank & ~(lcr_q[ueri_pkg::LCR_DLAB] & enh_ena);
    wire flow_adr = i_addr[2];

    // Write decode
    wire w_lcr  = wr_ev & is_adr(i_addr, ueri_pkg::ADR_LCR);
    wire w_dll  = wr_ev & dlab & is_adr(i_addr, ueri_pkg::ADR_DATA);
    wire w_dlm  = wr_ev & dlab & is_adr(i_addr, ueri_pkg::ADR_IER);
    wire w_dld  = wr_ev & dlab & enh_ena & is_adr(i_addr, ueri_pkg::ADR_ISR);
    wire w_thr  = wr_ev & std_bank & is_adr(i_addr, ueri_pkg::ADR_DATA);
    wire w_ier  = wr_ev & std_bank & is_adr(i_addr, ueri_pkg::ADR_IER);
    wire w_fcr  = wr_ev & std_bank & is_adr(i_addr, ueri_pkg::ADR_ISR);
    wire w_scr  = wr_ev & ~enh_bank & is_adr(i_addr, ueri_pkg::ADR_SCR);
    wire w_trg  = wr_ev & enh_bank & is_adr(i_addr, ueri_pkg::ADR_DATA);
    wire w_feature_control = wr_ev & enh_bank & is_adr(i_addr, ueri_pkg::ADR_IER);
    wire w_efr  = wr_ev & enh_bank & is_adr(i_addr, ueri_pkg::ADR_ISR);
    wire w_flow = wr_ev & enh_bank & flow_adr;

    // Read decode of side-effect registers
    wire r_rhr = rd_ev & std_bank & is_adr(i_addr, ueri_pkg::ADR_DATA);
    wire r_isr = rd_ev & isr_vis & is_adr(i_addr, ueri_pkg::ADR_ISR);
    wire r_lsr = rd_ev & ~enh_bank & is_adr(i_addr, ueri_pkg::ADR_LSR);
    wire r_msr = rd_ev & ~enh_bank & is_adr(i_addr, ueri_pkg::ADR_MSR);

    // Upper mask bits only move when the enhanced set is unlocked
    wire [7:0] ier_d = enh_ena ? i_wdata : {ier_q[7:4], i_wdata[3:0]};
    // Other control bits are ignored unless FIFO enable is written as one
    wire [1:0] fcr_tx_trig = enh_ena ? i_wdata[5:4] : fcr_q[5:4];
    wire [7:0] fcr_d = i_wdata[ueri_pkg::FCR_EN] ? {i_wdata[7:6], fcr_tx_trig, i_wdata[3], 3'h1}
                                                 : {fcr_q[7:1], 1'b0};

    // Standard bank registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lcr_q <= ueri_pkg::REG8_RST;
            ier_q <= ueri_pkg::REG8_RST;
            fcr_q <= ueri_pkg::REG8_RST;
            spr_q <= ueri_pkg::REG8_RST;
        end else begin
            if (w_lcr) begin
                lcr_q <= i_wdata;
            end
            if (w_ier) begin
                ier_q <= ier_d;
            end
            if (w_fcr) begin
                fcr_q <= fcr_d;
            end
            if (w_scr & ~feature_control_q[ueri_pkg::FEATURE_CONTROL_SEL]) begin
                spr_q <= i_wdata;
            end
        end
    end

    // Divisor registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            dll_q <= ueri_pkg::REG8_RST;
            dlm_q <= ueri_pkg::REG8_RST;
            dld_q <= ueri_pkg::DLD_RST;
        end else begin
            if (w_dll) begin
                dll_q <= i_wdata;
            end
            if (w_dlm) begin
                dlm_q <= i_wdata;
            end
            if (w_dld) begin
                dld_q <= i_wdata[3:0];
            end
        end
    end

    // Enhanced bank registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            trg_q  <= ueri_pkg::REG8_RST;
            feature_control_q <= ueri_pkg::REG8_RST;
            efr_q  <= ueri_pkg::REG8_RST;
            enhanced_mode_select_q <= ueri_pkg::REG8_RST;
        end else begin
            if (w_trg) begin
                trg_q <= i_wdata;
            end
            if (w_feature_control) begin
                feature_control_q <= i_wdata;
            end
            if (w_efr) begin
                efr_q <= i_wdata;
            end
            // Mode select shares the scratch address when selected
            if (w_scr & feature_control_q[ueri_pkg::FEATURE_CONTROL_SEL]) begin
                enhanced_mode_select_q <= i_wdata;
            end
        end
    end

    // Flow-control characters, indexed by the low address bits
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flow
            always_ff @(posedge i_mclk or negedge i_rstn) begin
                if (!i_rstn) begin
                    flow_q[gi] <= ueri_pkg::REG8_RST;
                end else if (w_flow & (i_addr[1:0] == 2'(gi))) begin
                    flow_q[gi] <= i_wdata;
                end
            end
        end
    endgenerate

    // Receive conditions
    wire fifo_en  = fcr_q[ueri_pkg::FCR_EN];
    wire rx_has   = (i_rx_level != '0);
    wire rx_trig  = (i_rx_level >= i_rx_trig);
    wire rx_src   = ier_q[ueri_pkg::IER_RX] & (fifo_en ? rx_trig : rx_has);

    // Transmit ready condition depends on FIFO mode
    wire tx_ready = fifo_en ? i_tx_below_trig : i_thr_empty;
    logic tx_rdy_q;    // Previous transmit ready level
    logic tx_pend_q;   // Transmit ready interrupt pending
    logic ovr_q;       // Sticky overrun flag
    logic lsr_pend_q;  // Line status interrupt pending

    // Mask bit 1 rising while already empty fires at once
    wire tx_en_rise = w_ier & ier_d[ueri_pkg::IER_TX] & ~ier_q[ueri_pkg::IER_TX] & tx_ready;
    wire tx_set     = (tx_ready & ~tx_rdy_q & ier_q[ueri_pkg::IER_TX]) | tx_en_rise;

    // Line status events: overrun at once, others as selected
    wire err_imm = enhanced_mode_select_q[ueri_pkg::ENHANCED_MODE_SELECT_IMM];
    wire err_ev  = err_imm ? i_err_recv : (r_rhr & (i_head_err != 3'h0));
    wire lsr_set = i_overrun | err_ev;

    // Enabled sources
    wire lsr_src = ier_q[ueri_pkg::IER_LS] & lsr_pend_q;
    wire tx_src  = ier_q[ueri_pkg::IER_TX] & tx_pend_q;
    wire msr_src = ier_q[ueri_pkg::IER_MS] & (i_msr[3:0] != 4'h0);

    // Priority encode of the pending source
    wire [5:0] isr_code = lsr_src ? ueri_pkg::ISR_LSR :
                          rx_src  ? ueri_pkg::ISR_RXD :
                          tx_src  ? ueri_pkg::ISR_TXR :
                          msr_src ? ueri_pkg::ISR_MSR : ueri_pkg::ISR_NONE;
    wire [7:0] isr_val  = {fifo_en, fifo_en, isr_code};
    wire       isr_tx   = (isr_code == ueri_pkg::ISR_TXR);

    // Transmit cleared by status read reporting it or holding write
    wire tx_clr = w_thr | (r_isr & isr_tx);

    // Pending flags, set wins over clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_rdy_q   <= 1'b0;
            tx_pend_q  <= 1'b0;
            ovr_q      <= 1'b0;
            lsr_pend_q <= 1'b0;
        end else begin
            tx_rdy_q   <= tx_ready;
            tx_pend_q  <= tx_set | (tx_pend_q & ~tx_clr);
            ovr_q      <= i_overrun | (ovr_q & ~r_lsr);
            lsr_pend_q <= lsr_set | (lsr_pend_q & ~r_lsr);
        end
    end

    // Line status word; polled mode reads it with all masks clear
    wire [7:0] lsr_val = {i_fifo_err_any,
                          i_tx_all_empty,
                          i_thr_empty,
                          i_head_err,
                          ovr_q,
                          rx_has};

    // Level count select, receive or transmit
    wire [7:0] lvl_rx  = 8'(i_rx_level);
    wire [7:0] lvl_tx  = 8'(i_tx_level);
    wire [7:0] lvl_val = enhanced_mode_select_q[0] ? lvl_tx : lvl_rx;

    // Read data selection per bank and address
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (enh_bank) begin
            case (i_addr)
                3'h0:    rd_mux = lvl_val;
                3'h1:    rd_mux = feature_control_q;
                3'h2:    rd_mux = efr_q;
                3'h3:    rd_mux = lcr_q;
                default: rd_mux = flow_adr ? flow_q[i_addr[1:0]] : 8'h00;
            endcase
        end else begin
            case (i_addr)
                3'h0:    rd_mux = dlab ? (id_sel ? P_REV_ID : dll_q) : i_rhr_data;
                3'h1:    rd_mux = dlab ? (id_sel ? P_DEV_ID : dlm_q) : ier_q;
                3'h2:    rd_mux = isr_vis ? isr_val : {4'h0, dld_q};
                3'h3:    rd_mux = lcr_q;
                3'h5:    rd_mux = lsr_val;
                3'h6:    rd_mux = i_msr;
                3'h7:    rd_mux = feature_control_q[ueri_pkg::FEATURE_CONTROL_SEL] ? lvl_rx : spr_q;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // Bus outputs and channel strobes, all registered
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata       <= 8'h00;
            o_rdata_oe_n  <= 1'b1;
            o_rhr_rd      <= 1'b0;
            o_msr_rd      <= 1'b0;
            o_thr_wr      <= 1'b0;
            o_thr_data    <= 8'h00;
            o_rx_fifo_rst <= 1'b0;
            o_tx_fifo_rst <= 1'b0;
        end else begin
            if (rd_ev) begin
                o_rdata <= rd_mux;
            end
            o_rdata_oe_n  <= ~rd_act;
            o_rhr_rd      <= r_rhr;
            o_msr_rd      <= r_msr;
            o_thr_wr      <= w_thr;
            if (w_thr) begin
                o_thr_data <= i_wdata;
            end
            o_rx_fifo_rst <= w_fcr & i_wdata[ueri_pkg::FCR_EN] & i_wdata[ueri_pkg::FCR_RXRST];
            o_tx_fifo_rst <= w_fcr & i_wdata[ueri_pkg::FCR_EN] & i_wdata[ueri_pkg::FCR_TXRST];
        end
    end

    // Configuration views
    assign o_line_control         = lcr_q;
    assign o_fifo_control         = fcr_q;
    assign o_divisor              = {dlm_q, dll_q};
    assign o_divisor_fraction     = dld_q;
    assign o_fifo_trigger_level   = trg_q;
    assign o_feature_control      = feature_control_q;
    assign o_enhanced_function    = efr_q;
    assign o_enhanced_mode_select = enhanced_mode_select_q;
    assign o_flow_chars           = {flow_q[3], flow_q[2], flow_q[1], flow_q[0]};
    // Interrupt line follows any enabled source
    assign o_int = lsr_src | rx_src | tx_src | msr_src;

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence s_tx_enable;
        w_ier & i_wdata[ueri_pkg::IER_TX] & ~ier_q[ueri_pkg::IER_TX] & tx_ready;
    endsequence

    sequence s_tx_quiet;
        ~w_thr & ~r_isr;
    endsequence

    div_low_map_a: assert property (w_dll |=> dll_q == $past(i_wdata))
        else $error("divisor low not written");
    mask_gate_a: assert property ((ier_q[3:0] == 4'h0) |-> !o_int)
        else $error("interrupt with all masks clear");
    rx_below_trig_a: assert property (fifo_en & ~rx_trig & ~lsr_src |-> isr_code != ueri_pkg::ISR_RXD)
        else $error("receive status held below trigger");
    rx_at_trig_a: assert property (fifo_en & rx_trig & ier_q[0] |-> o_int)
        else $error("no interrupt at trigger level");
    ready_bit_a: assert property (lsr_val[0] == (i_rx_level != '0))
        else $error("data ready bit wrong");
    ovr_flag_a: assert property (i_overrun |=> ovr_q && lsr_pend_q)
        else $error("overrun not flagged");
    tx_immediate_a: assert property (s_tx_enable |=> tx_pend_q && o_int)
        else $error("transmit enable did not interrupt");
    lsr_clear_a: assert property (r_lsr & ~lsr_set |=> !lsr_pend_q)
        else $error("line status read did not clear");
    tx_clear_a: assert property (w_thr & ~tx_set |=> !tx_pend_q ##1 (tx_pend_q == $past(tx_set)))
        else $error("holding write did not clear transmit");
    err_delay_a: assert property (~err_imm & i_err_recv & ~i_overrun & ~r_rhr & ~lsr_pend_q
                                  |=> !lsr_pend_q)
        else $error("delayed error raised early");

endmodule

// ===== test/ueri_host.sv
`timescale 1ns/100ps
// Host processor model on the parallel register bus
module ueri_host (
    // Clock
    input  wire logic       i_mclk,
    // Bus pins toward the device
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic [2:0]      o_addr,
    output logic [7:0]      o_wdata,
    // Read data from the device
    input  wire logic [7:0] i_rdata
);
    // Idle bus at time zero
    initial begin
        o_cs_n  = 1'b1;
        o_rd_n  = 1'b1;
        o_wr_n  = 1'b1;
        o_addr  = 3'h0;
        o_wdata = 8'h00;
    end
    // One access; strobe held 5 edges so the synced event and answer land
    task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge i_mclk);
        o_addr  = a;
        o_wdata = d;
        o_cs_n  = 1'b0;
        o_rd_n  = !rd;
        o_wr_n  = rd;
        repeat (5) @(posedge i_mclk);
        q = i_rdata;
        @(negedge i_mclk);
        o_cs_n  = 1'b1;
        o_rd_n  = 1'b1;
        o_wr_n  = 1'b1;
        // Released pins show garbage, not the last value
        o_addr  = ~a;
        o_wdata = ~d;
        // Gap of 4 cycles keeps strobe high long enough
        repeat (4) @(negedge i_mclk);
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic       i_mclk, i_rstn, i_cs_n, i_rd_n, i_wr_n, o_int;
    logic [2:0] i_addr, i_head_err;
    logic [7:0] i_wdata, o_rdata, i_rhr_data, i_msr, q;
    logic [6:0] i_rx_level, i_rx_trig, i_tx_level;
    logic       i_overrun, i_err_recv, i_fifo_err_any, i_tx_below_trig, i_thr_empty, i_tx_all_empty;
    logic [7:0] o_fifo_control, o_feature_control, o_enhanced_function, o_enhanced_mode_select;
    logic [15:0] o_divisor;
    logic [31:0] o_flow_chars, rnd, e;
    int         n_mismatch, checks_done;
    // Clock of 100 ns
    always #50 i_mclk = ~i_mclk;
    ueri_host i_host (.i_mclk, .o_cs_n(i_cs_n), .o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr),
        .o_wdata(i_wdata), .i_rdata(o_rdata));
    ueri_regs i_ueri_regs (.i_mclk, .i_rstn, .i_cs_n, .i_rd_n, .i_wr_n, .i_addr, .i_wdata, .o_rdata,
        .o_rdata_oe_n(), .i_rx_level, .i_rx_trig, .i_rhr_data, .i_overrun, .i_err_recv, .i_head_err,
        .i_fifo_err_any, .i_tx_level, .i_tx_below_trig, .i_thr_empty, .i_tx_all_empty, .i_msr,
        .o_rhr_rd(), .o_msr_rd(), .o_thr_wr(), .o_thr_data(), .o_rx_fifo_rst(), .o_tx_fifo_rst(),
        .o_line_control(), .o_fifo_control, .o_divisor, .o_divisor_fraction(), .o_fifo_trigger_level(),
        .o_feature_control, .o_enhanced_function, .o_enhanced_mode_select, .o_flow_chars, .o_int);
    // Random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected line status from the channel inputs, overrun already read away
    function automatic logic [7:0] lsr_exp();
        return {i_fifo_err_any, i_tx_all_empty, i_thr_empty, i_head_err, 1'b0, |i_rx_level};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_host.access(1'b0, a, d, x);
    endtask
    task automatic rd(input logic [2:0] a);
        i_host.access(1'b1, a, 8'h00, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_int(input logic exp);
        chk({31'h0, o_int}, {31'h0, exp});
    endtask
    // One-cycle pulse on an event input
    task automatic pulse(input logic ovr);
        i_overrun  = ovr;
        i_err_recv = !ovr;
        tick(1);
        i_overrun  = 1'b0;
        i_err_recv = 1'b0;
        tick(3);
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog about ten times the roughly 500 cycles the sequence needs
    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        {i_mclk, i_rstn, i_overrun, i_err_recv, i_fifo_err_any, i_tx_below_trig} = 6'h00;
        {i_thr_empty, i_tx_all_empty, i_head_err, i_msr, i_rhr_data} = 21'h0;
        {i_rx_level, i_tx_level, i_rx_trig} = {7'h00, 7'h00, 7'h08};
        {n_mismatch, checks_done, rnd} = {32'h0, 32'h0, 32'hd133};
        repeat (2) @(posedge i_mclk);
        tick(1);
        i_rstn = 1'b1;
        chk_int(1'b0);
        rd(ueri_pkg::ADR_IER);
        chk(q, 8'h00);
        // Divisor bank with random value
        rnd = lfsr(rnd);
        wr(ueri_pkg::ADR_LCR, 8'h80);
        wr(3'h0, rnd[7:0]);
        wr(3'h1, rnd[15:8]);
        rd(3'h0);
        chk(q, rnd[7:0]);
        rd(3'h1);
        chk(q, rnd[15:8]);
        chk(o_divisor, rnd[15:0]);
        // Enhanced bank
        wr(ueri_pkg::ADR_LCR, ueri_pkg::LCR_ENH_KEY);
        for (int i = 4; i < 8; i++) begin
            rnd = lfsr(rnd);
            e[8*(i-4)+:8] = rnd[7:0];
            wr(3'(i), rnd[7:0]);
        end
        chk(o_flow_chars, e);
        wr(3'h2, 8'h10);
        wr(3'h1, 8'h40);
        chk(o_enhanced_function, 8'h10);
        chk(o_feature_control, 8'h40);
        wr(ueri_pkg::ADR_LCR, 8'h03);
        // Transmit ready, no FIFO
        i_thr_empty = 1'b1;
        wr(ueri_pkg::ADR_IER, 8'h02);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_ISR);
        chk(q, {2'b00, ueri_pkg::ISR_TXR});
        chk_int(1'b0);
        i_thr_empty = 1'b0;
        tick(3);
        i_thr_empty = 1'b1;
        tick(3);
        chk_int(1'b1);
        wr(ueri_pkg::ADR_DATA, 8'h5a);
        chk_int(1'b0);
        // Modem status
        wr(ueri_pkg::ADR_IER, 8'h08);
        i_msr = 8'h01;
        tick(2);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_MSR);
        chk(q, 8'h01);
        i_msr = 8'h00;
        // Line status: overrun at once, other errors on readout
        wr(ueri_pkg::ADR_IER, 8'h04);
        pulse(1'b1);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_LSR);
        chk(q[1], 1'b1);
        chk_int(1'b0);
        pulse(1'b0);
        chk_int(1'b0);
        {i_head_err, i_rx_level, i_rhr_data} = {3'b010, 7'h01, 8'h3c};
        rd(ueri_pkg::ADR_DATA);
        chk(q, 8'h3c);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_LSR);
        chk(q[4:2], 3'b010);
        chk_int(1'b0);
        {i_head_err, i_rx_level} = 10'h0;
        wr(ueri_pkg::ADR_SCR, 8'h40);
        chk(o_enhanced_mode_select, 8'h40);
        pulse(1'b0);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_LSR);
        // FIFO receive trigger
        wr(ueri_pkg::ADR_ISR, 8'h01);
        chk(o_fifo_control[0], 1'b1);
        wr(ueri_pkg::ADR_IER, 8'h01);
        i_rx_level = 7'd7;
        tick(2);
        chk_int(1'b0);
        i_rx_level = 7'd8;
        tick(2);
        chk_int(1'b1);
        rd(ueri_pkg::ADR_ISR);
        chk(q, {2'b11, ueri_pkg::ISR_RXD});
        i_rx_level = 7'd7;
        tick(2);
        chk_int(1'b0);
        // Priority of line status over receive
        wr(ueri_pkg::ADR_IER, 8'h05);
        i_rx_level = 7'd8;
        pulse(1'b1);
        rd(ueri_pkg::ADR_ISR);
        chk(q, {2'b11, ueri_pkg::ISR_LSR});
        rd(ueri_pkg::ADR_LSR);
        rd(ueri_pkg::ADR_ISR);
        chk(q, {2'b11, ueri_pkg::ISR_RXD});
        // Polled mode with random channel status
        wr(ueri_pkg::ADR_IER, 8'h00);
        repeat (12) begin
            rnd = lfsr(rnd);
            {i_head_err, i_fifo_err_any, i_thr_empty, i_tx_all_empty, i_tx_below_trig} = rnd[6:0];
            {i_rx_level, i_tx_level} = {1'b0, rnd[13:8] | 6'h01, rnd[22:16]};
            tick(2);
            rd(ueri_pkg::ADR_LSR);
            chk(q, lsr_exp());
            chk_int(1'b0);
        end
        complete_run();
    end
endmodule
